// ==== rtl/scc_params.svh ====
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// Register indices; byte address is four times the index
`define SCC_IDX_PRIMARY     6'h00
`define SCC_IDX_SECONDARY   6'h01
`define SCC_IDX_STATUS      6'h03
`define SCC_IDX_IRQ_STAT    6'h08
`define SCC_IDX_IRQ_MASK    6'h09

// Primary control fields
`define SCC_P_MAIN_IRQ      7
`define SCC_P_ENABLE        6
`define SCC_P_TX_IRQ        5
`define SCC_P_ROLE          4
`define SCC_P_POL           3
`define SCC_P_PHASE         2
`define SCC_P_SS_OE         1
`define SCC_P_LSB           0

// Secondary control fields
`define SCC_S_FAULT_EN      4
`define SCC_S_BIDIR_OE      3
`define SCC_S_WAIT_STOP     1
`define SCC_S_PIN_CTRL      0
`define SCC_S_WMASK         8'h1b

// Status fields
`define SCC_ST_DONE         7
`define SCC_ST_FAULT        4
`define SCC_ST_TXE          5

// Reset values
`define SCC_PRIMARY_RST     8'h00
`define SCC_SECONDARY_RST   8'h00
`define SCC_IRQ_RST         3'h0

// Serial edge counts per byte
`define SCC_EDGES_PER_BYTE  5'h10

`endif

// ==== rtl/scc_pkg.sv ====
`default_nettype none

package scc_pkg;

  typedef struct packed {
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic ss;
    logic ss_oe;
    logic sck;
    logic sck_oe;
  } scc_pins_t;

  typedef struct packed {
    logic sck;
    logic ss;
    logic mosi;
    logic miso;
  } scc_pin_in_t;

  typedef struct packed {
    logic       sample;
    logic       rx_bit;
    logic [2:0] bit_idx;
  } scc_rx_t;

endpackage

`default_nettype wire

// ==== rtl/scc_ctrl.sv ====
// Functional notes
// - The interrupt rises on transfer-done or mode-fault only while the main interrupt enable is set.
// - With system enable clear the unit is idle, its flags are cleared and it drives no pin.
// - The interrupt rises on transmit-empty only while the transmit interrupt enable is set.
// - Role select picks slave at 0 and master at 1, and any change of role forces idle.
// - Polarity sets the idle level of SCK, and both ends must agree on it.
// - Phase 0 samples on odd SCK edges 1 to 15, phase 1 on even edges 2 to 16.
// - Bit order shifts MSB first at 0 and LSB first at 1, data register MSB stays at bit 7.
// - As master a changed polarity, phase, select-out, order, fault-enable or pin-control bit aborts to idle.
// - As master in bidirectional mode a changed output enable aborts to idle.
// - As master the select pin is unused, a fault input or a select output per fault-enable and select-out.
// - Fault enable allows mode-fault detection, and when clear the master ignores the select pin.
// - In bidirectional mode the output enable gates MOSI as master and MISO as slave.
// - Wait-stop keeps SCK generation in wait mode at 0 and stops it at 1.
// - Master pins: normal MISO in and MOSI out, bidirectional MOSI in or in/out and MISO unused.
// - Slave pins: normal MISO out and MOSI in, bidirectional MISO in or in/out and MOSI unused.
// - Both control registers read and write at any time, and reserved secondary bits ignore writes.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`include "scc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module scc_ctrl
  import scc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        done_flag_i,
  input  wire logic        tx_empty_flag_i,
  input  wire logic        busy_i,
  input  wire logic        sck_gen_i,
  input  wire logic        tx_bit_i,
  input  wire logic        wait_mode_i,
  input  wire scc_pin_in_t pins_i,
  output scc_pins_t        pins_o,
  output scc_rx_t          rx_o,
  output logic             idle_force_o,
  output logic             sck_run_o,
  output logic             lsb_first_o,
  output logic             irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [7:0]  primary_q;
  logic [7:0]  secondary_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic        fault_q;
  logic [5:0]  idx;
  logic        acc;
  logic        wr;
  logic        hit;
  logic        wr_pri;
  logic        wr_sec;
  logic [7:0]  pri_new;
  logic [7:0]  sec_new;
  logic [7:0]  status;

  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s,
                                       input logic [7:0] m);
    lane0 = s[0] ? ((old & ~m) | (d[7:0] & m)) : old;
  endfunction

  assign idx       = paddr_i[7:2];
  assign acc       = psel_i & penable_i;
  assign wr        = acc & pwrite_i;
  assign hit       = (idx == `SCC_IDX_PRIMARY) | (idx == `SCC_IDX_SECONDARY) |
                     (idx == `SCC_IDX_STATUS) | (idx == `SCC_IDX_IRQ_STAT) |
                     (idx == `SCC_IDX_IRQ_MASK);
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~hit;
  assign wr_pri    = wr & (idx == `SCC_IDX_PRIMARY);
  assign wr_sec    = wr & (idx == `SCC_IDX_SECONDARY);
  assign pri_new   = lane0(primary_q, pwdata_i, pstrb_i, 8'hff);
  assign sec_new   = lane0(secondary_q, pwdata_i, pstrb_i, `SCC_S_WMASK);

  logic en;
  logic master;
  logic pol;
  logic phase;
  logic ss_oe;
  logic fault_en;
  logic bidir_oe;
  logic bidir;

  assign en       = primary_q[`SCC_P_ENABLE];
  assign master   = primary_q[`SCC_P_ROLE];
  assign pol      = primary_q[`SCC_P_POL];
  assign phase    = primary_q[`SCC_P_PHASE];
  assign ss_oe    = primary_q[`SCC_P_SS_OE];
  assign fault_en = secondary_q[`SCC_S_FAULT_EN];
  assign bidir_oe = secondary_q[`SCC_S_BIDIR_OE];
  assign bidir    = secondary_q[`SCC_S_PIN_CTRL];

  always_comb
  begin
    status                = 8'h00;
    status[`SCC_ST_DONE]  = en & done_flag_i;
    status[`SCC_ST_FAULT] = fault_q;
    status[`SCC_ST_TXE]   = en & tx_empty_flag_i;
    prdata_o              = 32'h0000_0000;
    case (idx)
      `SCC_IDX_PRIMARY:   prdata_o[7:0] = primary_q;
      `SCC_IDX_SECONDARY: prdata_o[7:0] = secondary_q;
      `SCC_IDX_STATUS:    prdata_o[7:0] = status;
      `SCC_IDX_IRQ_STAT:  prdata_o[2:0] = irq_stat_q;
      `SCC_IDX_IRQ_MASK:  prdata_o[2:0] = irq_mask_q;
      default:            prdata_o      = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      primary_q   <= `SCC_PRIMARY_RST;
      secondary_q <= `SCC_SECONDARY_RST;
    end
    else
    begin
      if (wr_pri)
        primary_q <= pri_new;
      if (wr_sec)
        secondary_q <= sec_new;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Abort on setting change
  logic abort;
  logic [7:0] pri_diff;
  logic [7:0] sec_diff;

  assign pri_diff = pri_new ^ primary_q;
  assign sec_diff = sec_new ^ secondary_q;

  always_comb
  begin
    abort = 1'b0;
    if (wr_pri & pri_diff[`SCC_P_ROLE])
      abort = 1'b1;
    if (master & wr_pri & (pri_diff[`SCC_P_POL] | pri_diff[`SCC_P_PHASE] |
        pri_diff[`SCC_P_SS_OE] | pri_diff[`SCC_P_LSB]))
      abort = 1'b1;
    if (master & wr_sec & (sec_diff[`SCC_S_FAULT_EN] |
        sec_diff[`SCC_S_PIN_CTRL]))
      abort = 1'b1;
    if (master & bidir & wr_sec & sec_diff[`SCC_S_BIDIR_OE])
      abort = 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      idle_force_o <= 1'b1;
    else
      idle_force_o <= ~en | abort | fault_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  scc_pin_in_t meta_q;
  scc_pin_in_t sync_q;
  logic        sck_old_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q    <= '{sck: 1'b0, ss: 1'b1, mosi: 1'b0, miso: 1'b0};
      sync_q    <= '{sck: 1'b0, ss: 1'b1, mosi: 1'b0, miso: 1'b0};
      sck_old_q <= 1'b0;
    end
    else
    begin
      meta_q    <= pins_i;
      sync_q    <= meta_q;
      sck_old_q <= sync_q.sck;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode fault
  logic fault_in;
  assign fault_in = en & master & fault_en & ~ss_oe & ~sync_q.ss;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      fault_q <= 1'b0;
    else if (~en)
      fault_q <= 1'b0;
    else if (fault_in)
      fault_q <= 1'b1;
    else if (wr_pri)
      fault_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Slave edge counter and sampling
  logic       sck_edge;
  logic       slave_on;
  logic [4:0] edge_cnt_q;
  logic [4:0] edge_nxt;
  logic       odd_edge;

  assign sck_edge = sync_q.sck ^ sck_old_q;
  assign slave_on = en & ~master & ~sync_q.ss;
  assign edge_nxt = edge_cnt_q + 5'h01;
  assign odd_edge = edge_nxt[0];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      edge_cnt_q <= 5'h00;
    else if (~slave_on | idle_force_o)
      edge_cnt_q <= 5'h00;
    else if (sck_edge & (edge_cnt_q != `SCC_EDGES_PER_BYTE))
      edge_cnt_q <= edge_nxt;
  end

  function automatic logic [2:0] bit_pos(input logic [4:0] e,
                                         input logic lsb);
    logic [2:0] n;
    n = 3'((e - 5'h01) >> 1);
    bit_pos = lsb ? n : 3'h7 - n;
  endfunction

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rx_o <= '0;
    else
    begin
      rx_o.sample  <= slave_on & ~idle_force_o & sck_edge &
                      (edge_cnt_q != `SCC_EDGES_PER_BYTE) &
                      (odd_edge ^ phase);
      rx_o.rx_bit  <= bidir ? sync_q.miso : sync_q.mosi;
      rx_o.bit_idx <= bit_pos(edge_nxt,
                              primary_q[`SCC_P_LSB]);
      if (master)
        rx_o.rx_bit <= bidir ? sync_q.mosi : sync_q.miso;
    end
  end

  assign lsb_first_o = primary_q[`SCC_P_LSB];
  //////////////////////////////////////////////////////////////////////////
  // Pin drive
  assign sck_run_o = en & master &
                     ~(wait_mode_i & secondary_q[`SCC_S_WAIT_STOP]);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pins_o <= '0;
    else
    begin
      pins_o <= '0;
      if (en)
      begin
        if (master)
        begin
          pins_o.sck     <= pol ^ (sck_gen_i & sck_run_o);
          pins_o.sck_oe  <= 1'b1;
          pins_o.mosi    <= tx_bit_i;
          pins_o.mosi_oe <= ~bidir | bidir_oe;
          pins_o.ss      <= ~busy_i;
          pins_o.ss_oe   <= fault_en & ss_oe;
        end
        else
        begin
          pins_o.miso    <= tx_bit_i;
          pins_o.miso_oe <= ~sync_q.ss & (~bidir | bidir_oe);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [2:0] ev_lvl;
  logic [2:0] ev_old_q;
  logic [2:0] ev_rise;
  logic [2:0] gate;

  assign ev_lvl  = {en & tx_empty_flag_i, fault_q, en & done_flag_i};
  assign ev_rise = ev_lvl & ~ev_old_q;
  assign gate    = {primary_q[`SCC_P_TX_IRQ],
                    primary_q[`SCC_P_MAIN_IRQ],
                    primary_q[`SCC_P_MAIN_IRQ]};

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ev_old_q   <= `SCC_IRQ_RST;
      irq_stat_q <= `SCC_IRQ_RST;
      irq_mask_q <= `SCC_IRQ_RST;
    end
    else
    begin
      ev_old_q <= ev_lvl;
      if (wr & (idx == `SCC_IDX_IRQ_MASK) & pstrb_i[0])
        irq_mask_q <= pwdata_i[2:0];
      if (~en)
        irq_stat_q <= `SCC_IRQ_RST;
      else if (wr & (idx == `SCC_IDX_IRQ_STAT) & pstrb_i[0])
        irq_stat_q <= (irq_stat_q & ~pwdata_i[2:0]) | ev_rise;
      else
        irq_stat_q <= irq_stat_q | ev_rise;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q & gate);
  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_IRQ_MAIN: assert property (
    irq_o |-> ((|irq_stat_q[1:0]) & primary_q[`SCC_P_MAIN_IRQ]) |
              (irq_stat_q[2] & primary_q[`SCC_P_TX_IRQ]))
    else $error("interrupt without enabled cause");

  AST_DISABLED: assert property (
    ~en ##1 ~en |-> (pins_o == '0) && idle_force_o && !fault_q)
    else $error("disabled unit not idle");

  AST_TX_IRQ: assert property (
    (irq_stat_q == 3'h4) && irq_mask_q[2] && !primary_q[`SCC_P_TX_IRQ]
    |-> !irq_o)
    else $error("tx empty interrupt while disabled");

  AST_ROLE_ABORT: assert property (
    en && wr_pri && pri_diff[`SCC_P_ROLE] |=> idle_force_o)
    else $error("role change did not force idle");

  AST_SCK_IDLE: assert property (
    en && master && !sck_gen_i |=> pins_o.sck == $past(pol))
    else $error("sck idle level wrong");

  AST_SAMPLE_EDGE: assert property (
    rx_o.sample |-> edge_cnt_q[0] != $past(phase))
    else $error("sample on wrong edge");

  AST_BIT_ORDER: assert property (
    rx_o.sample && $past(edge_cnt_q) == 5'h00 |->
    rx_o.bit_idx == ($past(primary_q[`SCC_P_LSB]) ? 3'h0 : 3'h7))
    else $error("first bit index wrong");

  AST_CFG_ABORT: assert property (
    en && master && wr_pri && pri_diff[`SCC_P_PHASE] |=> idle_force_o)
    else $error("setting change did not abort");

  AST_BIDIR_ABORT: assert property (
    master && bidir && wr_sec && sec_diff[`SCC_S_BIDIR_OE] |=> idle_force_o)
    else $error("output enable change did not abort");

  AST_SS_OUT: assert property (
    en && master |=> pins_o.ss_oe == $past(fault_en & ss_oe))
    else $error("select output enable wrong");

  AST_FAULT_IGNORE: assert property (
    !fault_en && master && !fault_q |=> !fault_q)
    else $error("fault raised with detection off");

  AST_BIDIR_GATE: assert property (
    en && master && bidir && !bidir_oe |=> !pins_o.mosi_oe && !pins_o.miso_oe)
    else $error("bidir output not gated");

  AST_WAIT_STOP: assert property (
    wait_mode_i && secondary_q[`SCC_S_WAIT_STOP] |-> !sck_run_o)
    else $error("sck runs in wait with stop set");

  AST_NO_ABORT: assert property (
    en && wr_sec && sec_diff == 8'h00 && !fault_q && !abort ##1 en
    |-> !idle_force_o)
    else $error("abort without change");

  COV_ABORT: cover property (master && wr_pri && abort);
  COV_SAMPLE: cover property (rx_o.sample && phase);
  COV_FAULT: cover property ($rose(fault_q));
  COV_IRQ: cover property ($rose(irq_o));
endmodule

`default_nettype wire

// ==== tb/scc_peer.sv ====
`timescale 1ns/1ps
`default_nettype none

module scc_peer
  import scc_pkg::*;
(
  input  wire logic       hold_sel_i,
  output var scc_pin_in_t pins_o
);

  logic sck;
  logic sel;
  logic mosi;
  logic miso;

  ////////////////////////////////////////////////////////////
  assign pins_o = {sck, sel & ~hold_sel_i, mosi, miso};

  initial
  begin
    sck  = 1'b0;
    sel  = 1'b1;
    mosi = 1'b0;
    miso = 1'b0;
  end

  // One byte as link master; SCK stands still outside the frame
  task automatic send(input logic [7:0] d, input logic pol,
                      input logic pha, input logic lsb, input logic bid);
    sck = pol;
    #160;
    sel  = 1'b0;
    mosi = d[lsb ? 0 : 7];
    miso = bid ? mosi : ~mosi;
    #160;
    for (int e = 1; e <= 16; e++)
    begin
      sck  = ~sck;
      if (e[0] == pha && e < 16)
        mosi = d[lsb ? (e - pha) / 2 : 7 - (e - pha) / 2];
      miso = bid ? mosi : ~mosi;
      #160;
    end
    sel  = 1'b1;
    mosi = ~mosi;
  endtask

endmodule

`default_nettype wire

// ==== tb/spi_control_config_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module spi_control_config_bench;
  import scc_pkg::*;

  logic        clk_i;
  logic        rst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        done_i;
  logic        txe_i;
  logic        busy_i;
  logic        sckg_i;
  logic        txb_i;
  logic        wait_i;
  logic        hold_sel;
  scc_pin_in_t pin_in;
  scc_pins_t   pin_out;
  scc_rx_t     rx;
  logic        idle_o;
  logic        run_o;
  logic        lsb_o;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  p;
  logic [7:0]  s;
  logic [7:0]  b;
  logic [3:0]  q[$];
  int          err_count;
  int          comparisons;
  int          seed;

  scc_ctrl uut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .done_flag_i(done_i), .tx_empty_flag_i(txe_i),
    .busy_i(busy_i), .sck_gen_i(sckg_i), .tx_bit_i(txb_i),
    .wait_mode_i(wait_i), .pins_i(pin_in), .pins_o(pin_out), .rx_o(rx),
    .idle_force_o(idle_o), .sck_run_o(run_o), .lsb_first_o(lsb_o),
    .irq_o(irq));

  scc_peer peer (.hold_sel_i(hold_sel), .pins_o(pin_in));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= {i, 2'b00};
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_o !== 1'b1);
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Control write with the expected idle-force pulse
  task automatic ab(input logic [5:0] i, input logic [7:0] d);
    logic x;
    if (i == 6'h00)
      x = |((p ^ d) & (p[4] ? 8'h1f : 8'h10));
    else
      x = |((s ^ (d & 8'h1b)) & (p[4] ? (s[0] ? 8'h19 : 8'h11) : 8'h00));
    apb(1'b1, i, d);
    if (i == 6'h00)
      p = d;
    else
      s = d & 8'h1b;
    #1 chk(idle_o, x);
    @(posedge clk_i);
    #1 chk(idle_o, 1'b0);
  endtask

  task automatic pins_chk;
    @(posedge clk_i);
    #1;
    chk(pin_out.sck_oe, p[4]);
    chk(pin_out.ss_oe, p[4] & s[4] & p[1]);
    chk(pin_out.mosi_oe, p[4] & (!s[0] | s[3]));
    chk(pin_out.miso_oe, 1'b0);
    chk(run_o, p[4] & !(wait_i & s[1]));
    chk(lsb_o, p[0]);
    if (p[4])
      chk(pin_out.sck, p[3] ^ (sckg_i & !(wait_i & s[1])));
    if (p[4] & s[4] & p[1])
      chk(pin_out.ss, !busy_i);
    if (p[4] & !s[0])
      chk(pin_out.mosi, txb_i);
  endtask

  always @(posedge clk_i)
    if (rx.sample === 1'b1)
      q.push_back({rx.rx_bit, rx.bit_idx});

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h195503b6;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {done_i, txe_i, busy_i, sckg_i, txb_i, wait_i, hold_sel} = '0;
    err_count   = 0;
    comparisons = 0;
    rst_i       = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk(idle_o, 1'b1);
    apb(1'b0, 6'h00, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, 6'h01, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, 6'h05, 8'h00);
    chk(err, 1'b1);
    apb(1'b1, 6'h00, 8'h10);
    done_i <= 1'b1;
    apb(1'b0, 6'h03, 8'h00);
    chk(rd, 32'h0);
    chk({pin_out.mosi_oe, pin_out.miso_oe, pin_out.sck_oe}, 3'h0);
    done_i <= 1'b0;
    apb(1'b1, 6'h00, 8'h50);
    p = 8'h50;
    s = 8'h00;
    for (int r = 0; r < 40; r++)
    begin
      busy_i <= 1'($random(seed));
      txb_i  <= 1'($random(seed));
      wait_i <= 1'($random(seed));
      sckg_i <= 1'($random(seed));
      ab(6'h00, 8'($random(seed)) | 8'h40);
      ab(6'h01, 8'($random(seed)));
      ab(6'h00, p);
      pins_chk();
      apb(1'b0, 6'h00, 8'h00);
      chk(rd, {24'h0, p});
      apb(1'b0, 6'h01, 8'h00);
      chk(rd, {24'h0, s});
    end
    ab(6'h01, 8'h00);
    ab(6'h00, 8'h40);
    apb(1'b1, 6'h09, 8'h07);
    for (int j = 0; j < 2; j++)
      for (int k = 0; k < 4; k++)
      begin
        ab(6'h00, {k[0], 1'b1, k[1], 5'h00});
        apb(1'b1, 6'h08, 8'h07);
        done_i <= (j == 0);
        txe_i  <= (j == 1);
        repeat (3) @(posedge clk_i);
        #1;
        if (j == 1)
          chk(irq, k[1]);
        else
          chk(irq, k[0]);
        @(posedge clk_i);
        done_i <= 1'b0;
        txe_i  <= 1'b0;
      end
    apb(1'b1, 6'h09, 8'h00);
    #1 chk(irq, 1'b0);
    apb(1'b1, 6'h09, 8'h07);
    #1 chk(irq, 1'b1);
    apb(1'b1, 6'h08, 8'h07);
    #1 chk(irq, 1'b0);
    ab(6'h00, 8'hd0);
    ab(6'h01, 8'h10);
    hold_sel <= 1'b1;
    repeat (8) @(posedge clk_i);
    apb(1'b0, 6'h03, 8'h00);
    chk(rd[4], 1'b1);
    #1 chk(idle_o, 1'b1);
    chk(irq, 1'b1);
    hold_sel <= 1'b0;
    repeat (8) @(posedge clk_i);
    apb(1'b1, 6'h00, 8'hd0);
    apb(1'b1, 6'h08, 8'h07);
    ab(6'h01, 8'h00);
    hold_sel <= 1'b1;
    repeat (8) @(posedge clk_i);
    apb(1'b0, 6'h03, 8'h00);
    chk(rd[4], 1'b0);
    #1 chk(idle_o, 1'b0);
    hold_sel <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int v = 0; v < 16; v++)
    begin
      ab(6'h00, {4'h4, v[1], v[0], 1'b0, v[2]});
      ab(6'h01, {7'h00, v[3]});
      b = 8'($random(seed));
      q.delete();
      peer.send(b, v[1], v[0], v[2], v[3]);
      repeat (8) @(posedge clk_i);
      chk(q.size(), 8);
      chk(pin_out.miso, txb_i);
      chk(pin_out.miso_oe, 1'b0);
      foreach (q[i])
      begin
        chk(q[i][2:0], v[2] ? i : 7 - i);
        chk(q[i][3], b[q[i][2:0]]);
      end
    end
    conclude();
  end

endmodule

`default_nettype wire
